//--- include/ccp_cfg.svh
// Constants for the codec control port: addresses, field positions, timing
`ifndef CCP_CFG_SVH
`define CCP_CFG_SVH
`define CCP_SPI_ADDR 7'h4f
`define CCP_I2C_ADDR_HI 5'h13
`define CCP_PTR_STEP_BIT 7
`define CCP_PTR_IDX_W 7
`define CCP_BIT_CLK_NS 80
`define CCP_CLK_NS 5
`define CCP_HALF_CYC ((`CCP_BIT_CLK_NS / 2) / `CCP_CLK_NS)
`endif

//--- include/ccp_pkg.sv
// Types shared by both ends of the codec control port
package ccp_pkg;
   typedef enum logic [4:0] {
      CCP_IDLE = 5'b00001,
      CCP_ADDR = 5'b00010,
      CCP_PTR = 5'b00100,
      CCP_DATA = 5'b01000,
      CCP_SKIP = 5'b10000
   } ccp_phase_t;
   typedef enum logic [5:0] {
      CCP_H_IDLE = 6'b000001,
      CCP_H_LOW = 6'b000010,
      CCP_H_HIGH = 6'b000100,
      CCP_H_START = 6'b001000,
      CCP_H_STOP = 6'b010000,
      CCP_H_DONE = 6'b100000
   } ccp_hstate_t;
endpackage

//--- include/ccp_link_if.sv
// Pin-level link between host and codec control port
`timescale 1ns/1ps
interface ccp_link_if;
   logic rst_n;
   logic ctrl_bit_clock;
   logic addr0_or_select_pin;
   logic ctrl_serial_in;
   logic dev_out;
   logic dev_out_en_n;
   logic host_sda_out;
   logic host_sda_en_n;
   logic high_addr_strap;
   // Resolved data-out / SDA wire: open drain with pull-up for I2C
   logic ctrl_serial_out;
   assign ctrl_serial_out = (!dev_out_en_n) ? dev_out :
      ((!host_sda_en_n) ? host_sda_out : 1'b1);
   logic sda;
   assign sda = (!dev_out_en_n ? dev_out : 1'b1) &
      (!host_sda_en_n ? host_sda_out : 1'b1);
   modport dev (input rst_n, ctrl_bit_clock, addr0_or_select_pin,
      ctrl_serial_in, sda, high_addr_strap,
      output dev_out, dev_out_en_n);
   modport host (output rst_n, ctrl_bit_clock, addr0_or_select_pin,
      ctrl_serial_in, host_sda_out, host_sda_en_n, high_addr_strap,
      input ctrl_serial_out, sda);
endinterface

//--- logic/ccp_sync2.sv
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module ccp_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Pins in, synchronised out
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_sync
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q;
   logic [W-1:0] sync_d;
   initial begin
      if (W < 1) $error("ccp_sync2 width must be positive");
   end
   // Next values: first stage read only by second
   always_comb begin
      meta_d = pin_in;
      sync_d = meta_q;
   end
   // Registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end
   assign pin_sync = sync_q;
endmodule // ccp_sync2

//--- logic/ccp_device.sv
// Codec control port slave: SPI or I2C register access
`timescale 1ns/1ps
`include "ccp_cfg.svh"
module ccp_device import ccp_pkg::*; #(
   parameter int NREG = 128
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Link pins
   ccp_link_if.dev link,
   // User side: register contents and strap
   input wire logic low_addr_strap,
   output logic spi_mode,
   output logic [7:0] reg_file [NREG],
   output logic [7:0] reg_wr_idx,
   output logic reg_wr_pulse
);
   logic [4:0] pins;
   logic rst_n_s;
   logic scl_s;
   logic sel_s;
   logic din_s;
   logic sda_s;
   logic scl_p_q, sel_p_q, sda_p_q;
   logic scl_p_d, sel_p_d, sda_p_d;
   logic [7:0] regs_q [NREG];
   logic [7:0] regs_d [NREG];
   logic spi_q, spi_d;
   logic [1:0] strap_q, strap_d;
   ccp_phase_t ph_q, ph_d;
   logic [7:0] sh_q, sh_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] ptr_q, ptr_d;
   logic rd_q, rd_d;
   logic ack_q, ack_d;
   logic oen_n_q, oen_n_d;
   logic out_q, out_d;
   logic [7:0] tx_q, tx_d;
   logic wr_q, wr_d;
   logic [7:0] widx_q, widx_d;
   logic rise, fall, start, stop, live;
   logic [7:0] byte_in;
   logic [7:0] ptr_nx;
   initial begin
      if (NREG < 1 || NREG > 256) $error("NREG out of range");
   end
   // Synchronise all pins but the address straps before use
   ccp_sync2 #(.W(5)) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .pin_in({link.rst_n, link.ctrl_bit_clock, link.addr0_or_select_pin,
         link.ctrl_serial_in, link.sda}),
      .pin_sync(pins)
   );
   assign {rst_n_s, scl_s, sel_s, din_s, sda_s} = pins;
   // Pointer step with optional auto increment
   function automatic logic [7:0] step(input logic [7:0] p);
      if (p[`CCP_PTR_STEP_BIT])
         step = {p[7], p[6:0] + 7'h01};
      else
         step = p;
   endfunction
   // Pointer after one byte, shared by both modes
   assign ptr_nx = step(ptr_q);
   // Edge detection on synchronised pins
   assign live = rst_n_s;
   assign rise = live & scl_s & ~scl_p_q;
   assign fall = live & ~scl_s & scl_p_q;
   assign start = live & ~spi_q & scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop = live & ~spi_q & scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign byte_in = {sh_q[6:0], spi_q ? din_s : sda_s};
   // Protocol next state
   always_comb begin
      regs_d = regs_q;
      spi_d = spi_q;
      strap_d = strap_q;
      ph_d = ph_q;
      sh_d = sh_q;
      cnt_d = cnt_q;
      ptr_d = ptr_q;
      rd_d = rd_q;
      ack_d = ack_q;
      oen_n_d = oen_n_q;
      out_d = out_q;
      tx_d = tx_q;
      wr_d = 1'b0;
      widx_d = widx_q;
      scl_p_d = scl_s;
      sel_p_d = sel_s;
      sda_p_d = sda_s;
      if (!live) begin
         // Hold registers, mode, phase, pointer and counter cleared, catch straps during reset
         for (int i = 0; i < NREG; i++) regs_d[i] = 8'h00;
         spi_d = 1'b0;
         strap_d = {link.high_addr_strap, low_addr_strap};
         ph_d = CCP_IDLE;
         ptr_d = 8'h00;
         oen_n_d = 1'b1;
         cnt_d = 4'h0;
      end else if (!spi_q && sel_p_q && !sel_s) begin
         spi_d = 1'b1;
         ph_d = CCP_ADDR;
         cnt_d = 4'h0;
         oen_n_d = 1'b1;
      end else if (spi_q) begin
         if (sel_s) begin
            ph_d = CCP_IDLE;
            oen_n_d = 1'b1;
         end else if (!sel_s && sel_p_q) begin
            ph_d = CCP_ADDR;
            cnt_d = 4'h0;
         end else if (rise && ph_q != CCP_IDLE && ph_q != CCP_SKIP) begin
            sh_d = byte_in;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7) begin
               cnt_d = 4'h0;
               case (ph_q)
                  CCP_ADDR: begin
                     if (byte_in[7:1] == `CCP_SPI_ADDR) begin
                        rd_d = byte_in[0];
                        ph_d = byte_in[0] ? CCP_DATA : CCP_PTR;
                        tx_d = regs_q[ptr_q[`CCP_PTR_IDX_W-1:0]];
                     end else ph_d = CCP_SKIP;
                  end
                  CCP_PTR: begin
                     ptr_d = byte_in;
                     ph_d = CCP_DATA;
                  end
                  CCP_DATA: if (!rd_q) begin
                     regs_d[ptr_q[`CCP_PTR_IDX_W-1:0]] = byte_in;
                     wr_d = 1'b1;
                     widx_d = ptr_q;
                     ptr_d = step(ptr_q);
                  end
                  default: ph_d = CCP_SKIP;
               endcase
            end
         end else if (fall && ph_q == CCP_DATA && rd_q) begin
            oen_n_d = 1'b0;
            out_d = tx_q[7];
            tx_d = {tx_q[6:0], 1'b0};
            if (cnt_q == 4'h7) begin
               ptr_d = step(ptr_q);
               tx_d = regs_q[ptr_nx[`CCP_PTR_IDX_W-1:0]];
            end
         end else if (rise && ph_q == CCP_DATA && rd_q) begin
            cnt_d = (cnt_q == 4'h7) ? 4'h0 : cnt_q + 4'h1;
         end
      end else begin
         // I2C mode
         if (start) begin
            ph_d = CCP_ADDR;
            cnt_d = 4'h0;
            ack_d = 1'b0;
            oen_n_d = 1'b1;
         end else if (stop) begin
            ph_d = CCP_IDLE;
            oen_n_d = 1'b1;
         end else if (rise && ph_q != CCP_IDLE && ph_q != CCP_SKIP) begin
            if (ack_q) begin
               // Host acknowledge after a byte we sent
               if (rd_q && sda_s) ph_d = CCP_SKIP;
            end else begin
               sh_d = byte_in;
               cnt_d = cnt_q + 4'h1;
            end
         end else if (fall && ph_q != CCP_IDLE && ph_q != CCP_SKIP) begin
            oen_n_d = 1'b1;
            if (ack_q) begin
               ack_d = 1'b0;
               cnt_d = 4'h0;
               if (rd_q) begin
                  oen_n_d = tx_q[7]; // Open drain: release for ones
                  out_d = 1'b0;
                  tx_d = {tx_q[6:0], 1'b0};
               end
            end else if (rd_q && ph_q == CCP_DATA) begin
               // Bit 0 goes out at the fall after the seventh rise
               if (cnt_q == 4'h8) begin
                  oen_n_d = 1'b1;
                  ack_d = 1'b1;
                  ptr_d = ptr_nx;
                  tx_d = regs_q[ptr_nx[`CCP_PTR_IDX_W-1:0]];
               end else begin
                  oen_n_d = tx_q[7];
                  out_d = 1'b0;
                  tx_d = {tx_q[6:0], 1'b0};
               end
            end else if (cnt_q == 4'h8) begin
               ack_d = 1'b1;
               case (ph_q)
                  CCP_ADDR: begin
                     if (sh_q[7:1] == {`CCP_I2C_ADDR_HI, strap_q}) begin
                        oen_n_d = 1'b0;
                        out_d = 1'b0;
                        rd_d = sh_q[0];
                        ph_d = sh_q[0] ? CCP_DATA : CCP_PTR;
                        tx_d = regs_q[ptr_q[`CCP_PTR_IDX_W-1:0]];
                        cnt_d = 4'h0;
                     end else begin
                        ph_d = CCP_SKIP;
                        ack_d = 1'b0;
                     end
                  end
                  CCP_PTR: begin
                     ptr_d = sh_q;
                     ph_d = CCP_DATA;
                     oen_n_d = 1'b0;
                     out_d = 1'b0;
                  end
                  default: begin
                     regs_d[ptr_q[`CCP_PTR_IDX_W-1:0]] = sh_q;
                     wr_d = 1'b1;
                     widx_d = ptr_q;
                     ptr_d = step(ptr_q);
                     oen_n_d = 1'b0;
                     out_d = 1'b0;
                  end
               endcase
            end
         end
      end
   end
   // Registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < NREG; i++) regs_q[i] <= 8'h00;
         spi_q <= 1'b0;
         strap_q <= 2'b00;
         ph_q <= CCP_IDLE;
         sh_q <= 8'h00;
         cnt_q <= 4'h0;
         ptr_q <= 8'h00;
         rd_q <= 1'b0;
         ack_q <= 1'b0;
         oen_n_q <= 1'b1;
         out_q <= 1'b1;
         tx_q <= 8'h00;
         wr_q <= 1'b0;
         widx_q <= 8'h00;
         scl_p_q <= 1'b0;
         sel_p_q <= 1'b0;
         sda_p_q <= 1'b1;
      end else begin
         regs_q <= regs_d;
         spi_q <= spi_d;
         strap_q <= strap_d;
         ph_q <= ph_d;
         sh_q <= sh_d;
         cnt_q <= cnt_d;
         ptr_q <= ptr_d;
         rd_q <= rd_d;
         ack_q <= ack_d;
         oen_n_q <= oen_n_d;
         out_q <= out_d;
         tx_q <= tx_d;
         wr_q <= wr_d;
         widx_q <= widx_d;
         scl_p_q <= scl_p_d;
         sel_p_q <= sel_p_d;
         sda_p_q <= sda_p_d;
      end
   end
   // Outputs
   assign link.dev_out = out_q;
   assign link.dev_out_en_n = oen_n_q;
   assign spi_mode = spi_q;
   assign reg_file = regs_q;
   assign reg_wr_idx = widx_q;
   assign reg_wr_pulse = wr_q;
endmodule // ccp_device

//--- logic/ccp_host.sv
// Host end: SPI master that writes or reads one register byte
`timescale 1ns/1ps
`include "ccp_cfg.svh"
module ccp_host import ccp_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Link pins
   ccp_link_if.host link,
   // User request: write sends ptr+data, read sends address+read then shifts out req_data
   input wire logic req_valid,
   input wire logic req_read,
   input wire logic [7:0] req_ptr,
   input wire logic [7:0] req_data,
   input wire logic dev_reset_n,
   input wire logic strap_hi,
   output logic req_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data
);
   localparam int HALF = (`CCP_HALF_CYC < 1) ? 1 : `CCP_HALF_CYC;
   ccp_hstate_t st_q, st_d;
   logic [23:0] sh_q, sh_d;
   logic [4:0] nbit_q, nbit_d;
   logic [7:0] div_q, div_d;
   logic [7:0] rx_q, rx_d;
   logic rd_q, rd_d;
   logic sck_q, sck_d;
   logic sel_q, sel_d;
   logic mosi_q, mosi_d;
   logic rv_q, rv_d;
   logic miso_m_q, miso_q;
   // Transfer sequencer; host edges and partial write
   always_comb begin
      st_d = st_q;
      sh_d = sh_q;
      nbit_d = nbit_q;
      div_d = div_q;
      rx_d = rx_q;
      rd_d = rd_q;
      sck_d = sck_q;
      sel_d = sel_q;
      mosi_d = mosi_q;
      rv_d = 1'b0;
      case (st_q)
         CCP_H_IDLE: begin
            sel_d = 1'b1;
            sck_d = 1'b0;
            if (req_valid) begin
               rd_d = req_read;
               sh_d = {`CCP_SPI_ADDR, req_read, req_read ? req_data :
                  req_ptr, req_data};
               nbit_d = req_read ? 5'd16 : 5'd24;
               st_d = CCP_H_START;
               div_d = 8'h00;
            end
         end
         CCP_H_START: begin
            sel_d = 1'b0;
            mosi_d = sh_q[23];
            div_d = div_q + 8'h01;
            if (div_q == 8'(HALF - 1)) begin
               div_d = 8'h00;
               st_d = CCP_H_HIGH;
            end
         end
         CCP_H_HIGH: begin
            sck_d = 1'b1;
            div_d = div_q + 8'h01;
            if (div_q == 8'(HALF - 1)) begin
               div_d = 8'h00;
               rx_d = {rx_q[6:0], miso_q};
               sh_d = {sh_q[22:0], 1'b0};
               nbit_d = nbit_q - 5'd1;
               st_d = CCP_H_LOW;
            end
         end
         CCP_H_LOW: begin
            sck_d = 1'b0;
            mosi_d = sh_q[23];
            div_d = div_q + 8'h01;
            if (div_q == 8'(HALF - 1)) begin
               div_d = 8'h00;
               st_d = (nbit_q == 5'd0) ? CCP_H_STOP : CCP_H_HIGH;
            end
         end
         CCP_H_STOP: begin
            sel_d = 1'b1;
            st_d = CCP_H_DONE;
            rv_d = 1'b1;
         end
         default: st_d = CCP_H_IDLE;
      endcase
   end
   // Registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_q <= CCP_H_IDLE;
         sh_q <= 24'h000000;
         nbit_q <= 5'd0;
         div_q <= 8'h00;
         rx_q <= 8'h00;
         rd_q <= 1'b0;
         sck_q <= 1'b0;
         sel_q <= 1'b1;
         mosi_q <= 1'b0;
         rv_q <= 1'b0;
         miso_m_q <= 1'b0;
         miso_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sh_q <= sh_d;
         nbit_q <= nbit_d;
         div_q <= div_d;
         rx_q <= rx_d;
         rd_q <= rd_d;
         sck_q <= sck_d;
         sel_q <= sel_d;
         mosi_q <= mosi_d;
         rv_q <= rv_d;
         miso_m_q <= link.ctrl_serial_out;
         miso_q <= miso_m_q;
      end
   end
   assign req_ready = (st_q == CCP_H_IDLE);
   assign rsp_valid = rv_q;
   assign rsp_data = rx_q;
   assign link.ctrl_bit_clock = sck_q;
   assign link.addr0_or_select_pin = sel_q;
   assign link.ctrl_serial_in = mosi_q;
   assign link.host_sda_out = 1'b1;
   assign link.host_sda_en_n = 1'b1;
   assign link.rst_n = dev_reset_n;
   assign link.high_addr_strap = strap_hi;
endmodule // ccp_host

//--- test/ccp_checker.sv
// Assertions on the SPI link between host and device ends
`timescale 1ns/1ps
`include "ccp_cfg.svh"
module ccp_checker (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Link pins
   input wire logic rst_n,
   input wire logic ctrl_bit_clock,
   input wire logic addr0_or_select_pin,
   input wire logic ctrl_serial_in,
   input wire logic dev_out,
   input wire logic dev_out_en_n
);
   logic bclk_q;
   logic [4:0] cnt_q, cnt_d;
   logic [7:0] hdr_q, hdr_d;
   logic [3:0] age_q, age_d;
   logic rd, wr;
   // Count bit clock rises per frame, keep header, age since fall
   always_comb begin
      cnt_d = cnt_q;
      hdr_d = hdr_q;
      age_d = (age_q == 4'hf) ? age_q : age_q + 4'h1;
      if (bclk_q && !ctrl_bit_clock)
         age_d = 4'h0;
      if (addr0_or_select_pin) begin
         cnt_d = 5'h00;
      end else if (!bclk_q && ctrl_bit_clock) begin
         cnt_d = cnt_q + 5'h01;
         if (cnt_q < 5'h08)
            hdr_d = {hdr_q[6:0], ctrl_serial_in};
      end
   end
   // Register the helper state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bclk_q <= 1'b0;
         cnt_q <= 5'h00;
         hdr_q <= 8'h00;
         age_q <= 4'hf;
      end else begin
         bclk_q <= ctrl_bit_clock;
         cnt_q <= cnt_d;
         hdr_q <= hdr_d;
         age_q <= age_d;
      end
   end
   // Frame direction once the header byte is in
   assign rd = !addr0_or_select_pin && cnt_q >= 5'h08 && hdr_q[0];
   assign wr = !addr0_or_select_pin && cnt_q >= 5'h08 && !hdr_q[0];
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence read_begins;
      $rose(rd);
   endsequence
   sequence drive_after_fall;
      dev_out_en_n [*4] ##[1:12] !dev_out_en_n;
   endsequence
   a_reset_quiet: assert property (
      !rst_n [*5] |-> dev_out_en_n) else $error("drives in link reset");
   a_idle_release: assert property (
      addr0_or_select_pin [*8] |-> dev_out_en_n) else $error("drives idle");
   a_write_release: assert property (
      wr |-> dev_out_en_n) else $error("drives during write");
   a_read_drive: assert property (
      read_begins |-> drive_after_fall) else $error("read drive timing");
   a_out_on_fall: assert property (
      !dev_out_en_n && $changed(dev_out) |-> age_q <= 4'h6)
      else $error("output moved away from falling edge");
   a_clock_still: assert property (
      addr0_or_select_pin [*3] |-> $stable(ctrl_bit_clock))
      else $error("bit clock runs outside frame");
   a_data_low: assert property (
      !addr0_or_select_pin && $past(!addr0_or_select_pin) &&
      $changed(ctrl_serial_in) |-> !ctrl_bit_clock)
      else $error("host data moved with clock high");
   a_addr_sent: assert property (
      cnt_q == 5'h08 && $changed(cnt_q) |-> hdr_q[7:1] == `CCP_SPI_ADDR)
      else $error("wrong device address sent");
   a_frame_len: assert property (
      $rose(addr0_or_select_pin) |->
      (cnt_q == 5'h18 && !hdr_q[0]) || (cnt_q == 5'h10 && hdr_q[0]))
      else $error("frame length wrong");
endmodule // ccp_checker

//--- test/testbench.sv
// Self-checking bench: SPI host to device, bench-driven I2C device
`timescale 1ns/1ps
`define CMP(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
   $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module testbench;
   logic core_clk, rst, req_valid, req_read, req_ready, rsp_valid;
   logic dev_reset_n, spi_mode, spi_mode_b, wr_pulse, rd_bit;
   logic [7:0] req_ptr, req_data, rsp_data, wr_idx, got;
   logic [7:0] regs [128];
   logic [7:0] regs_b [128];
   int errors, comparisons, n_wr;
   ccp_link_if link();
   ccp_link_if link_b();
   ccp_host i_ccp_host (.core_clk(core_clk), .rst(rst), .link(link.host),
      .req_valid(req_valid), .req_read(req_read), .req_ptr(req_ptr),
      .req_data(req_data), .dev_reset_n(dev_reset_n), .strap_hi(1'b0),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   ccp_device i_ccp_device (.core_clk(core_clk), .rst(rst), .link(link.dev),
      .low_addr_strap(1'b0), .spi_mode(spi_mode), .reg_file(regs),
      .reg_wr_idx(wr_idx), .reg_wr_pulse(wr_pulse));
   ccp_device i_ccp_device_b (.core_clk(core_clk), .rst(rst),
      .link(link_b.dev), .low_addr_strap(1'b1), .spi_mode(spi_mode_b),
      .reg_file(regs_b), .reg_wr_idx(), .reg_wr_pulse());
   ccp_checker i_ccp_checker (.core_clk(core_clk), .rst(rst),
      .rst_n(link.rst_n), .ctrl_bit_clock(link.ctrl_bit_clock),
      .addr0_or_select_pin(link.addr0_or_select_pin),
      .ctrl_serial_in(link.ctrl_serial_in), .dev_out(link.dev_out),
      .dev_out_en_n(link.dev_out_en_n));
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Count stored bytes on the SPI device
   always @(negedge core_clk) begin
      if (wr_pulse === 1'b1)
         n_wr++;
   end
   task automatic hold(input int c);
      repeat (c) @(posedge core_clk);
   endtask
   // One host request, waiting for the response pulse
   task automatic spi(input logic r, input logic [7:0] p, input logic [7:0] d);
      int n;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_read <= r;
      req_ptr <= p;
      req_data <= d;
      n = 0;
      do @(negedge core_clk); while (req_ready !== 1'b1 && ++n < 100);
      @(posedge core_clk);
      req_valid <= 1'b0;
      n = 0;
      do @(negedge core_clk); while (rsp_valid !== 1'b1 && ++n < 1000);
      if (n >= 1000)
         errors++;
      repeat (12) @(negedge core_clk);
   endtask
   // I2C bit: data set while clock low, sampled mid clock high
   task automatic i2c_bit(input logic b, output logic r);
      link_b.ctrl_bit_clock <= 1'b0;
      hold(2);
      link_b.host_sda_en_n <= b;
      hold(6);
      link_b.ctrl_bit_clock <= 1'b1;
      hold(4);
      r = link_b.sda;
      hold(4);
   endtask
   // Start is cond(1,0), stop is cond(0,1): data moves with clock high
   task automatic cond(input logic a, input logic b);
      link_b.ctrl_bit_clock <= 1'b0;
      hold(2);
      link_b.host_sda_en_n <= a;
      hold(6);
      link_b.ctrl_bit_clock <= 1'b1;
      hold(8);
      link_b.host_sda_en_n <= b;
      hold(8);
   endtask
   task automatic i2c_send(input logic [7:0] v, input logic ack_exp);
      for (int i = 7; i >= 0; i--)
         i2c_bit(v[i], rd_bit);
      i2c_bit(1'b1, rd_bit);
      `CMP(rd_bit, ack_exp)
   endtask
   task automatic i2c_recv(input logic [7:0] exp, input logic last);
      got = 8'h00;
      for (int i = 0; i < 8; i++) begin
         i2c_bit(1'b1, rd_bit);
         got = {got[6:0], rd_bit};
      end
      i2c_bit(last, rd_bit);
      `CMP(got, exp)
   endtask
   task automatic summarize();
      $display("counts: %0d comparisons, %0d errors", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog
   initial begin
      #200000;
      errors++;
      summarize();
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req_read = 1'b0;
      req_ptr = 8'h00;
      req_data = 8'h00;
      dev_reset_n = 1'b0;
      link_b.rst_n = 1'b0;
      link_b.ctrl_bit_clock = 1'b1;
      link_b.addr0_or_select_pin = 1'b1;
      link_b.ctrl_serial_in = 1'b1;
      link_b.host_sda_out = 1'b0;
      link_b.host_sda_en_n = 1'b1;
      link_b.high_addr_strap = 1'b0;
      hold(3);
      rst <= 1'b0;
      hold(4);
      dev_reset_n <= 1'b1;
      link_b.rst_n <= 1'b1;
      hold(6);
      link_b.high_addr_strap <= 1'b1;
      hold(20);
      `CMP(spi_mode, 1'b0)
      `CMP(regs[7], 8'h00)
      $display("test reset done");
      spi(1'b0, 8'h06, 8'h5a);
      `CMP(regs[6], 8'h5a)
      `CMP(wr_idx, 8'h06)
      `CMP(spi_mode, 1'b1)
      spi(1'b1, 8'h00, 8'h00);
      `CMP(rsp_data, 8'h5a)
      spi(1'b1, 8'h00, 8'h00);
      `CMP(rsp_data, 8'h5a)
      spi(1'b0, 8'h07, 8'hc3);
      spi(1'b0, 8'h85, 8'h3c);
      `CMP(regs[5], 8'h3c)
      spi(1'b1, 8'h00, 8'h00);
      `CMP(rsp_data, 8'h5a)
      spi(1'b1, 8'h00, 8'h00);
      `CMP(rsp_data, 8'hc3)
      spi(1'b0, 8'hff, 8'h77);
      `CMP(regs[127], 8'h77)
      spi(1'b1, 8'h00, 8'h00);
      `CMP(rsp_data, 8'h00)
      $display("test spi done");
      dev_reset_n <= 1'b0;
      hold(10);
      `CMP(regs[6], 8'h00)
      `CMP(spi_mode, 1'b0)
      dev_reset_n <= 1'b1;
      hold(20);
      spi(1'b0, 8'h01, 8'h9c);
      `CMP(regs[1], 8'h9c)
      `CMP(n_wr, 5)
      $display("test link reset done");
      cond(1'b1, 1'b0);
      i2c_send(8'h9a, 1'b0);
      i2c_send(8'h83, 1'b0);
      i2c_send(8'ha4, 1'b0);
      i2c_send(8'h5b, 1'b0);
      cond(1'b0, 1'b1);
      `CMP(regs_b[3], 8'ha4)
      `CMP(regs_b[4], 8'h5b)
      cond(1'b1, 1'b0);
      i2c_send(8'h9e, 1'b1);
      i2c_send(8'h00, 1'b1);
      cond(1'b0, 1'b1);
      `CMP(spi_mode_b, 1'b0)
      cond(1'b1, 1'b0);
      i2c_send(8'h9a, 1'b0);
      i2c_send(8'h83, 1'b0);
      cond(1'b0, 1'b1);
      cond(1'b1, 1'b0);
      i2c_send(8'h9b, 1'b0);
      i2c_recv(8'ha4, 1'b0);
      i2c_recv(8'h5b, 1'b1);
      cond(1'b0, 1'b1);
      $display("test i2c done");
      summarize();
   end
endmodule // testbench
